// file: verilog/bus_cycle_seq.sv
// bus master sequencer for immediate and direct mode instruction cycles
`timescale 1ns/1ps
`include "seq_params.svh"
module bus_cycle_seq
   import seq_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire op_class_t   op_class,
   input  wire logic [15:0] start_addr,
   input  wire logic [15:0] store_data,
   input  wire logic [15:0] stack_ptr,
   input  wire logic [7:0]  bus_data_in,
   output logic [15:0]      bus_addr,
   output logic             bus_rw,
   output logic [7:0]       bus_data_out,
   output logic             bus_data_oe_n,
   output logic             busy,
   output logic             done,
   output logic [7:0]       opcode,
   output logic [15:0]      operand,
   output logic [15:0]      eff_addr,
   output logic [15:0]      next_pc,
   output logic             seq_err
);
   ////////////////////////////////////////////////////////////////////////////
   seq_state_t          state_r,   state_nxt;
   op_class_t           cls_r,     cls_nxt;
   logic [`STEP_W-1:0]  step_r,    step_nxt;
   cap_t                cap_r,     cap_nxt;
   addr_src_t           asrc_r,    asrc_nxt;
   logic                last_r,    last_nxt;
   logic [15:0]         fetch_r,   fetch_nxt;
   logic [15:0]         ea_r,      ea_nxt;
   logic [15:0]         store_r,   store_nxt;
   logic [15:0]         sp_r,      sp_nxt;
   logic [7:0]          opcode_r,  opcode_nxt;
   logic [15:0]         operand_r, operand_nxt;
   logic [15:0]         addr_r,    addr_nxt;
   logic                rw_r,      rw_nxt;
   logic [7:0]          dout_r,    dout_nxt;
   logic                oe_n_r,    oe_n_nxt;
   logic                busy_r,    busy_nxt;
   logic                done_r,    done_nxt;
   logic                err_r,     err_nxt;
   logic [`STEP_W-1:0]  run_len_r, run_len_nxt;

   op_class_t           plan_cls;
   logic [`STEP_W-1:0]  plan_step;
   addr_src_t           p_asrc;
   logic                p_wr;
   dat_src_t            p_dsrc;
   cap_t                p_cap;
   logic                p_last;
   logic                from_idle;
   logic                go;
   logic [15:0]         fetch_base;
   logic [15:0]         store_base;
   logic [15:0]         sp_base;

   assign from_idle  = (state_r == ST_IDLE) && start;
   assign go         = from_idle || (state_r == ST_RUN && !last_r);
   assign plan_cls   = from_idle ? op_class : cls_r;
   assign plan_step  = from_idle ? 3'd0 : step_r + 3'd1;
   assign fetch_base = from_idle ? start_addr : fetch_nxt;
   assign store_base = from_idle ? store_data : store_r;
   assign sp_base    = from_idle ? stack_ptr : sp_r;

   cycle_plan u_plan
   (
      .cls  (plan_cls),
      .step (plan_step),
      .asrc (p_asrc),
      .wr   (p_wr),
      .dsrc (p_dsrc),
      .cap  (p_cap),
      .last (p_last)
   );

   ////////////////////////////////////////////////////////////////////////////
   // capture what the bus returned in the cycle now ending, then set up the next one
   always_comb
   begin
      state_nxt   = state_r;
      cls_nxt     = cls_r;
      step_nxt    = step_r;
      fetch_nxt   = fetch_r;
      ea_nxt      = ea_r;
      store_nxt   = store_r;
      sp_nxt      = sp_r;
      opcode_nxt  = opcode_r;
      operand_nxt = operand_r;
      err_nxt     = err_r;
      run_len_nxt = run_len_r;
      done_nxt    = 1'b0;
      if (state_r == ST_RUN)
      begin
         case (cap_r)
            CP_PFX : if (bus_data_in != `PAGE_PREFIX) err_nxt = 1'b1;
            CP_OPC :
            begin
               opcode_nxt = bus_data_in;
               case (cls_r)
                  OC_IMM_IY_LD : if (bus_data_in != `OPC2_IMM_IY_LD) err_nxt = 1'b1;
                  OC_DIR_IY_LD : if (bus_data_in != `OPC2_DIR_IY_LD) err_nxt = 1'b1;
                  OC_DIR_IY_ST : if (bus_data_in != `OPC2_DIR_IY_ST) err_nxt = 1'b1;
                  OC_DIR_CALL  : if (bus_data_in != `OPC_DIR_CALL) err_nxt = 1'b1;
                  default      : err_nxt = err_r;
               endcase
            end
            CP_EAL  : ea_nxt = {`DIRECT_PAGE_HI, bus_data_in};
            CP_HI   : operand_nxt[15:8] = bus_data_in;
            CP_LO   : operand_nxt[7:0] = bus_data_in;
            default : operand_nxt = operand_r; // dummy reads land here and are dropped
         endcase
      end
      if (from_idle)
      begin
         state_nxt   = ST_RUN;
         cls_nxt     = op_class;
         step_nxt    = 3'd0;
         fetch_nxt   = start_addr;
         store_nxt   = store_data;
         sp_nxt      = stack_ptr;
         operand_nxt = 16'h0000;
         err_nxt     = 1'b0;
         run_len_nxt = 3'd1;
      end
      else if (state_r == ST_RUN && !last_r)
      begin
         step_nxt    = step_r + 3'd1;
         run_len_nxt = run_len_r + 3'd1;
      end
      else if (state_r == ST_RUN)
      begin
         state_nxt = ST_IDLE;
         done_nxt  = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus drive for the next cycle
   always_comb
   begin
      addr_nxt  = `IDLE_ADDR;
      rw_nxt    = `BUS_READ;
      dout_nxt  = 8'h00;
      oe_n_nxt  = 1'b1;
      cap_nxt   = CP_NONE;
      asrc_nxt  = AS_DUMMY;
      last_nxt  = 1'b0;
      busy_nxt  = (state_nxt == ST_RUN);
      if (go)
      begin
         cap_nxt  = p_cap;
         asrc_nxt = p_asrc;
         last_nxt = p_last;
         rw_nxt   = p_wr ? `BUS_WRITE : `BUS_READ;
         oe_n_nxt = !p_wr;
         case (p_asrc)
            AS_PC    : addr_nxt = fetch_base;
            AS_EA    : addr_nxt = ea_nxt;
            AS_EA1   : addr_nxt = ea_nxt + 16'h0001;
            AS_SP    : addr_nxt = sp_base;
            AS_SP1   : addr_nxt = sp_base - 16'h0001;
            default  : addr_nxt = `DUMMY_ADDR;
         endcase
         case (p_dsrc)
            DS_HI     : dout_nxt = store_base[15:8];
            DS_LO     : dout_nxt = store_base[7:0];
            DS_RET_LO : dout_nxt = fetch_base[7:0];
            DS_RET_HI : dout_nxt = fetch_base[15:8];
            default   : dout_nxt = 8'h00;
         endcase
      end
   end

   // the fetch pointer moves one past every instruction byte fetched
   logic [15:0] fetch_adv;
   assign fetch_adv = (go && p_asrc == AS_PC) ? fetch_base + 16'h0001 : fetch_nxt;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r   <= ST_IDLE;
         cls_r     <= OC_IMM8;
         step_r    <= 3'd0;
         cap_r     <= CP_NONE;
         asrc_r    <= AS_DUMMY;
         last_r    <= 1'b0;
         fetch_r   <= 16'h0000;
         ea_r      <= 16'h0000;
         store_r   <= 16'h0000;
         sp_r      <= 16'h0000;
         opcode_r  <= 8'h00;
         operand_r <= 16'h0000;
         addr_r    <= `IDLE_ADDR;
         rw_r      <= `BUS_READ;
         dout_r    <= 8'h00;
         oe_n_r    <= 1'b1;
         busy_r    <= 1'b0;
         done_r    <= 1'b0;
         err_r     <= 1'b0;
         run_len_r <= 3'd0;
      end
      else
      begin
         state_r   <= state_nxt;
         cls_r     <= cls_nxt;
         step_r    <= step_nxt;
         cap_r     <= cap_nxt;
         asrc_r    <= asrc_nxt;
         last_r    <= last_nxt;
         fetch_r   <= fetch_adv;
         ea_r      <= ea_nxt;
         store_r   <= store_nxt;
         sp_r      <= sp_nxt;
         opcode_r  <= opcode_nxt;
         operand_r <= operand_nxt;
         addr_r    <= addr_nxt;
         rw_r      <= rw_nxt;
         dout_r    <= dout_nxt;
         oe_n_r    <= oe_n_nxt;
         busy_r    <= busy_nxt;
         done_r    <= done_nxt;
         err_r     <= err_nxt;
         run_len_r <= run_len_nxt;
      end
   end

   assign bus_addr      = addr_r;
   assign bus_rw        = rw_r;
   assign bus_data_out  = dout_r;
   assign bus_data_oe_n = oe_n_r;
   assign busy          = busy_r;
   assign done          = done_r;
   assign opcode        = opcode_r;
   assign operand       = operand_r;
   assign eff_addr      = ea_r;
   assign next_pc       = fetch_r;
   assign seq_err       = err_r;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_iy_imm_start;
      state_r == ST_IDLE && start && op_class == OC_IMM_IY_LD;
   endsequence
   sequence s_iy_imm_body;
      cap_r == CP_PFX ##1 cap_r == CP_OPC ##1 cap_r == CP_HI ##1 (cap_r == CP_LO && last_r);
   endsequence
   sequence s_wide_store_hi;
      busy_r && !rw_r && asrc_r == AS_EA && (cls_r == OC_DIR16_ST || cls_r == OC_DIR_IY_ST);
   endsequence
   sequence s_call_push_lo;
      busy_r && !rw_r && asrc_r == AS_SP && cls_r == OC_DIR_CALL;
   endsequence

   AST_IMM8_LEN:     assert property (done_r && cls_r == OC_IMM8 |-> run_len_r == 3'd2)
      else $error("immediate 8-bit length wrong");
   AST_IMM16_LD_LEN: assert property (done_r && cls_r == OC_IMM16_LD |-> run_len_r == 3'd3)
      else $error("immediate 16-bit load length wrong");
   AST_IMM16_AR:     assert property (done_r && cls_r == OC_IMM16_AR |->
         run_len_r == 3'd4 && $past(addr_r) == 16'hffff)
      else $error("immediate 16-bit arithmetic sequence wrong");
   AST_IMM_IY_SEQ:   assert property (s_iy_imm_start |=> s_iy_imm_body)
      else $error("immediate Y load sequence wrong");
   AST_IMM_IY_LEN:   assert property (done_r && cls_r == OC_IMM_IY_LD |-> run_len_r == 3'd4)
      else $error("immediate Y load length wrong");
   AST_IMM_PFX_CP:   assert property (done_r && cls_r == OC_IMM_PFX_CP |->
         run_len_r == 3'd5 && $past(addr_r) == 16'hffff)
      else $error("prefixed compare sequence wrong");
   AST_FETCH_ASCEND: assert property ((busy_r && asrc_r == AS_PC) ##1 (busy_r && asrc_r == AS_PC) |->
         addr_r == $past(addr_r) + 16'h0001)
      else $error("instruction fetch not ascending");
   AST_DIRECT_PAGE:  assert property (busy_r && asrc_r == AS_EA |-> addr_r[15:8] == 8'h00)
      else $error("direct address high byte not zero");
   AST_DIR8_LD_LEN:  assert property (done_r && cls_r == OC_DIR8_LD |-> run_len_r == 3'd3)
      else $error("direct 8-bit length wrong");
   AST_DIR8_ST_WR:   assert property (busy_r && !rw_r && cls_r == OC_DIR8_ST |->
         last_r && !oe_n_r && dout_r == store_r[7:0])
      else $error("direct accumulator store wrong");
   AST_DIR8_ST_LEN:  assert property (done_r && cls_r == OC_DIR8_ST |-> run_len_r == 3'd3)
      else $error("direct accumulator store length wrong");
   AST_DIR16_LD_LO:  assert property (busy_r && cls_r == OC_DIR16_LD && asrc_r == AS_EA1 |->
         addr_r == ea_r + 16'h0001 && last_r)
      else $error("direct 16-bit load low byte wrong");
   AST_DIR16_LD_LEN: assert property (done_r && cls_r == OC_DIR16_LD |-> run_len_r == 3'd4)
      else $error("direct 16-bit load length wrong");
   AST_WIDE_ST_PAIR: assert property (s_wide_store_hi |=>
         !rw_r && addr_r == $past(addr_r) + 16'h0001 && dout_r == store_r[7:0])
      else $error("direct 16-bit store pair wrong");
   AST_DIR16_ST_LEN: assert property (done_r && cls_r == OC_DIR16_ST |-> run_len_r == 3'd4)
      else $error("direct 16-bit store length wrong");
   AST_DIR_IY_LEN:   assert property (done_r && (cls_r == OC_DIR_IY_LD || cls_r == OC_DIR_IY_ST) |->
         run_len_r == 3'd5)
      else $error("direct Y transfer length wrong");
   AST_DIR16_AR:     assert property (done_r && cls_r == OC_DIR16_AR |->
         run_len_r == 3'd5 && $past(addr_r) == 16'hffff)
      else $error("direct 16-bit arithmetic sequence wrong");
   AST_CALL_TARGET:  assert property (busy_r && cls_r == OC_DIR_CALL && cap_r == CP_EAL |=>
         addr_r == {8'h00, $past(bus_data_in)})
      else $error("direct call target wrong");
   AST_CALL_PUSH:    assert property (s_call_push_lo |=>
         !rw_r && last_r && asrc_r == AS_SP1 && addr_r == $past(addr_r) - 16'h0001)
      else $error("direct call return push wrong");
   AST_CALL_LEN:     assert property (done_r && cls_r == OC_DIR_CALL |-> run_len_r == 3'd5)
      else $error("direct call length wrong");
   // the dummy data would land at the edge ending the dummy cycle; the check compares the two cycles after it
   AST_DUMMY_DROP:   assert property (busy_r && asrc_r == AS_DUMMY |=> ##1
         ($stable(operand_r) && $stable(ea_r) && $stable(fetch_r) && $stable(opcode_r) && $stable(err_r)))
      else $error("dummy read changed state");
endmodule

// file: verilog/seq_params.svh
// constants for the immediate and direct mode bus cycle sequencer
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define DUMMY_ADDR     16'hffff
`define IDLE_ADDR      16'hffff
`define DIRECT_PAGE_HI 8'h00
`define PAGE_PREFIX    8'h18
`define OPC2_IMM_IY_LD 8'hec
`define OPC2_DIR_IY_LD 8'hde
`define OPC2_DIR_IY_ST 8'hdf
`define OPC_DIR_CALL   8'h9d
`define BUS_READ       1'b1
`define BUS_WRITE      1'b0
`define STEP_W         3
`endif

// file: verilog/seq_pkg.sv
// types shared by the bus cycle sequencer
package seq_pkg;
   typedef enum logic [3:0] {
      OC_IMM8       = 4'h0, OC_IMM16_LD = 4'h1, OC_IMM16_AR = 4'h2, OC_IMM_IY_LD = 4'h3,
      OC_IMM_PFX_CP = 4'h4, OC_DIR8_LD  = 4'h5, OC_DIR8_ST  = 4'h6, OC_DIR16_LD  = 4'h7,
      OC_DIR16_ST   = 4'h8, OC_DIR_IY_LD = 4'h9, OC_DIR_IY_ST = 4'ha, OC_DIR16_AR = 4'hb,
      OC_DIR_CALL   = 4'hc
   } op_class_t;
   typedef enum logic [2:0] {
      AS_PC = 3'h0, AS_EA = 3'h1, AS_EA1 = 3'h2, AS_DUMMY = 3'h3, AS_SP = 3'h4, AS_SP1 = 3'h5
   } addr_src_t;
   typedef enum logic [2:0] {
      DS_NONE = 3'h0, DS_HI = 3'h1, DS_LO = 3'h2, DS_RET_LO = 3'h3, DS_RET_HI = 3'h4
   } dat_src_t;
   typedef enum logic [2:0] {
      CP_NONE = 3'h0, CP_PFX = 3'h1, CP_OPC = 3'h2, CP_EAL = 3'h3, CP_HI = 3'h4, CP_LO = 3'h5
   } cap_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0, ST_RUN = 1'b1
   } seq_state_t;
endpackage

// file: verilog/cycle_plan.sv
// per-cycle plan: address source, direction, data source and capture for one step
`timescale 1ns/1ps
`include "seq_params.svh"
module cycle_plan
   import seq_pkg::*;
(
   input  wire op_class_t         cls,
   input  wire logic [`STEP_W-1:0] step,
   output addr_src_t              asrc,
   output logic                   wr,
   output dat_src_t               dsrc,
   output cap_t                   cap,
   output logic                   last
);
   logic                pfx, imm, wide, ar, st, call;
   logic [`STEP_W-1:0]  len;
   logic [`STEP_W-1:0]  s0;

   always_comb
   begin
      case (cls)
         OC_IMM8       : {pfx, imm, wide, ar, st, call, len} = {6'b010000, 3'd2};
         OC_IMM16_LD   : {pfx, imm, wide, ar, st, call, len} = {6'b011000, 3'd3};
         OC_IMM16_AR   : {pfx, imm, wide, ar, st, call, len} = {6'b011100, 3'd4};
         OC_IMM_IY_LD  : {pfx, imm, wide, ar, st, call, len} = {6'b111000, 3'd4};
         OC_IMM_PFX_CP : {pfx, imm, wide, ar, st, call, len} = {6'b111100, 3'd5};
         OC_DIR8_LD    : {pfx, imm, wide, ar, st, call, len} = {6'b000000, 3'd3};
         OC_DIR8_ST    : {pfx, imm, wide, ar, st, call, len} = {6'b000010, 3'd3};
         OC_DIR16_LD   : {pfx, imm, wide, ar, st, call, len} = {6'b001000, 3'd4};
         OC_DIR16_ST   : {pfx, imm, wide, ar, st, call, len} = {6'b001010, 3'd4};
         OC_DIR_IY_LD  : {pfx, imm, wide, ar, st, call, len} = {6'b101000, 3'd5};
         OC_DIR_IY_ST  : {pfx, imm, wide, ar, st, call, len} = {6'b101010, 3'd5};
         OC_DIR16_AR   : {pfx, imm, wide, ar, st, call, len} = {6'b001100, 3'd5};
         OC_DIR_CALL   : {pfx, imm, wide, ar, st, call, len} = {6'b000001, 3'd5};
         default       : {pfx, imm, wide, ar, st, call, len} = {6'b010000, 3'd2};
      endcase
      s0   = pfx ? step - 3'd1 : step;
      asrc = AS_PC;
      wr   = 1'b0;
      dsrc = DS_NONE;
      cap  = CP_NONE;
      if (pfx && step == 3'd0)
         cap = CP_PFX;
      else
      begin
         case (s0)
            3'd0 : cap = CP_OPC;
            3'd1 : cap = imm ? (wide ? CP_HI : CP_LO) : CP_EAL;
            3'd2 :
            begin
               if (imm)
                  cap = CP_LO;
               else
               begin
                  asrc = AS_EA;
                  if (st)
                  begin
                     wr   = 1'b1;
                     dsrc = wide ? DS_HI : DS_LO;
                  end
                  else if (!call)
                     cap = wide ? CP_HI : CP_LO;
               end
            end
            3'd3 :
            begin
               if (imm)
                  asrc = AS_DUMMY;
               else if (call)
               begin
                  asrc = AS_SP;
                  wr   = 1'b1;
                  dsrc = DS_RET_LO;
               end
               else
               begin
                  asrc = AS_EA1;
                  if (st)
                  begin
                     wr   = 1'b1;
                     dsrc = DS_LO;
                  end
                  else
                     cap = CP_LO;
               end
            end
            3'd4 :
            begin
               if (call)
               begin
                  asrc = AS_SP1;
                  wr   = 1'b1;
                  dsrc = DS_RET_HI;
               end
               else if (ar)
                  asrc = AS_DUMMY;
            end
            default : cap = CP_NONE;
         endcase
      end
      last = (step == len - 3'd1);
   end
endmodule

// file: sim/bus_mem.sv
// memory model answering the sequencer's bus cycles
`timescale 1ns/1ps
module bus_mem
(
   input  wire logic        ref_clk,
   input  wire logic [15:0] bus_addr,
   input  wire logic        bus_rw,
   input  wire logic [7:0]  bus_data_out,
   input  wire logic        bus_data_oe_n,
   output logic [7:0]       bus_data_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_r;
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   task automatic poke(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = pat(16'(i));
      last_r = 8'h00;
   end
   // while the sequencer writes, the read lines carry a toggling pattern, not the last byte
   assign bus_data_in = bus_rw ? mem[bus_addr] : ~last_r;
   always @(posedge ref_clk)
   begin
      if (!bus_rw && !bus_data_oe_n)
         mem[bus_addr] <= bus_data_out;
      last_r <= bus_data_in;
   end
endmodule

// file: sim/testbench.sv
// self-checking bench for the immediate and direct mode bus cycle sequencer
`timescale 1ns/1ps
module testbench;
   import seq_pkg::*;
   typedef struct {op_class_t cls; int len; int nf; int nd; int nw; bit w16; logic [15:0] a;} row_t;
   logic        ref_clk, resetn, start, bus_rw, bus_data_oe_n, busy, done, seq_err;
   op_class_t   op_class;
   logic [15:0] start_addr, store_data, stack_ptr, bus_addr, operand, eff_addr, next_pc;
   logic [7:0]  bus_data_in, bus_data_out, opcode;
   int          fail_count, num_checks;
   row_t        rows [13];
   bus_cycle_seq bus_cycle_seq_inst (.ref_clk(ref_clk), .resetn(resetn), .start(start), .op_class(op_class),
      .start_addr(start_addr), .store_data(store_data), .stack_ptr(stack_ptr), .bus_data_in(bus_data_in),
      .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
      .busy(busy), .done(done), .opcode(opcode), .operand(operand), .eff_addr(eff_addr), .next_pc(next_pc),
      .seq_err(seq_err));
   bus_mem bus_mem_inst (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_data_out(bus_data_out),
      .bus_data_oe_n(bus_data_oe_n), .bus_data_in(bus_data_in));
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      chk(name, {15'h0000, exp}, {15'h0000, got});
   endtask
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   function automatic logic [15:0] exp_addr(input row_t r, input int k, input logic [15:0] ea);
      int j;
      j = k - r.nf;
      if (j <= 0)
         return r.a + 16'(k - 1);
      if (r.cls == OC_DIR_CALL)
         return (j == 1) ? ea : (j == 2) ? stack_ptr : stack_ptr - 16'h0001;
      if (j <= r.nd)
         return ea + 16'(j - 1);
      return 16'hffff;
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // one instruction: place prefix or call opcode, start it, follow every bus cycle, check results
   task automatic run_row(input row_t r, input logic [7:0] pfx);
      logic [7:0]  sec, eab, wd;
      logic [15:0] ea, ret;
      bit          pre;
      pre = r.cls inside {OC_IMM_IY_LD, OC_IMM_PFX_CP, OC_DIR_IY_LD, OC_DIR_IY_ST};
      sec = (r.cls == OC_IMM_IY_LD) ? 8'hec : (r.cls == OC_DIR_IY_LD) ? 8'hde :
            (r.cls == OC_DIR_IY_ST) ? 8'hdf : 8'ha3;
      if (pre)
      begin
         bus_mem_inst.poke(r.a, pfx);
         bus_mem_inst.poke(r.a + 16'h0001, sec);
      end
      if (r.cls == OC_DIR_CALL)
         bus_mem_inst.poke(r.a, 8'h9d);
      eab = (r.nd > 0 || r.cls == OC_DIR_CALL) ? pat(r.a + 16'(r.nf - 1)) : 8'h00;
      ea = {8'h00, eab};
      ret = r.a + 16'(r.nf);
      @(posedge ref_clk);
      start <= 1'b1;
      op_class <= r.cls;
      start_addr <= r.a;
      @(posedge ref_clk);
      start <= 1'b0;
      for (int k = 1; k <= r.len; k++)
      begin
         if (k > 1)
            @(posedge ref_clk);
         #1;
         chk("bus_addr", exp_addr(r, k, ea), bus_addr);
         chk1("bus_rw", k <= r.len - r.nw, bus_rw);
         chk1("busy", 1'b1, busy);
         chk1("done early", 1'b0, done);
         if (k > r.len - r.nw)
         begin
            if (r.cls == OC_DIR_CALL)
               wd = (k == r.len) ? ret[15:8] : ret[7:0];
            else
               wd = (r.w16 && k != r.len) ? store_data[15:8] : store_data[7:0];
            chk("bus_data_out", {8'h00, wd}, {8'h00, bus_data_out});
            chk1("bus_data_oe_n", 1'b0, bus_data_oe_n);
         end
      end
      @(posedge ref_clk);
      #1;
      chk1("done", 1'b1, done);
      chk("idle bus_addr", 16'hffff, bus_addr);
      chk1("busy at done", 1'b0, busy);
      chk("next_pc", ret, next_pc);
      chk("opcode", {8'h00, pre ? sec : bus_mem_inst.mem[r.a]}, {8'h00, opcode});
      chk1("seq_err", pre && pfx != 8'h18, seq_err);
      if (eab != 8'h00)
         chk("eff_addr", ea, eff_addr);
      if (r.nw == 0 && r.cls != OC_DIR_CALL)
         chk("operand", (r.nd == 0) ? (r.w16 ? {pat(r.a + 16'(r.nf - 2)), pat(r.a + 16'(r.nf - 1))}
            : {8'h00, pat(r.a + 16'h0001)}) : (r.w16 ? {pat(ea), pat(ea + 16'h0001)}
            : {8'h00, pat(ea)}), operand);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      fail_count++;
      $display("mismatch watchdog expected finish seen hang");
      conclude();
   end
   initial
   begin
      fail_count = 0;
      num_checks = 0;
      resetn = 1'b0;
      start = 1'b0;
      op_class = OC_IMM8;
      start_addr = 16'h0000;
      store_data = 16'hb7c4;
      stack_ptr = 16'h0200;
      rows = '{'{OC_IMM8, 2, 2, 0, 0, 0, 16'h1000}, '{OC_IMM16_LD, 3, 3, 0, 0, 1, 16'h1013},
         '{OC_IMM16_AR, 4, 3, 0, 0, 1, 16'h1025}, '{OC_IMM_IY_LD, 4, 4, 0, 0, 1, 16'h1037},
         '{OC_IMM_PFX_CP, 5, 4, 0, 0, 1, 16'h1049}, '{OC_DIR8_LD, 3, 2, 1, 0, 0, 16'h105b},
         '{OC_DIR16_LD, 4, 2, 2, 0, 1, 16'h106d}, '{OC_DIR_IY_LD, 5, 3, 2, 0, 1, 16'h1080},
         '{OC_DIR16_AR, 5, 2, 2, 0, 1, 16'h1092}, '{OC_DIR8_ST, 3, 2, 1, 1, 0, 16'h10a4},
         '{OC_DIR16_ST, 4, 2, 2, 2, 1, 16'h10b6}, '{OC_DIR_IY_ST, 5, 3, 2, 2, 1, 16'h10c8},
         '{OC_DIR_CALL, 5, 2, 1, 2, 0, 16'h10da}};
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      #1;
      chk("reset bus_addr", 16'hffff, bus_addr);
      chk1("reset bus_rw", 1'b1, bus_rw);
      chk1("reset oe_n", 1'b1, bus_data_oe_n);
      chk1("reset busy", 1'b0, busy);
      chk1("reset done", 1'b0, done);
      chk("reset data_out", 16'h0000, {8'h00, bus_data_out});
      foreach (rows[i])
         run_row(rows[i], 8'h18);
      // wrong prefix flags an error but the sequence still runs its full length
      run_row(rows[3], 8'h19);
      // start held high: ignored while busy, taken again on the done cycle
      @(posedge ref_clk);
      start <= 1'b1;
      op_class <= OC_IMM8;
      start_addr <= 16'h1000;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("held start cycle2", 16'h1001, bus_addr);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("back to back cycle1", 16'h1000, bus_addr);
      // reset in the middle of a store write cycle returns the bus to idle at once
      @(posedge ref_clk);
      start <= 1'b1;
      op_class <= OC_DIR16_ST;
      start_addr <= 16'h10b6;
      repeat (2) @(posedge ref_clk);
      start <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk1("mid write rw", 1'b0, bus_rw);
      chk("mid write hi", 16'h00b7, {8'h00, bus_data_out});
      @(posedge ref_clk);
      resetn <= 1'b0;
      #1;
      chk("mid reset bus_addr", 16'hffff, bus_addr);
      chk1("mid reset rw", 1'b1, bus_rw);
      chk1("mid reset oe_n", 1'b1, bus_data_oe_n);
      chk1("mid reset busy", 1'b0, busy);
      @(posedge ref_clk);
      resetn <= 1'b1;
      run_row(rows[10], 8'h18);
      conclude();
   end
endmodule
